/* core/usf_engine.sv */
// How it works
// - A loop starts every 10, 20, 50, 100, 500 or 1000 ms as selected.
// - Configuration writes are ignored while the sequence runs.
// - The run bit starts and stops block execution.
// - Eighteen blocks, each with its own output link address.
// - A zero link address forwards the result nowhere.
// - A nonzero link receives the block result every loop, except for function code 0 or a link to a result address.
// - Thirty writable constant slots serve as operand sources.
// - An invalid block setup makes its result minus one.
// - Results are read only; links still route them onward.
// - Each block has a function code and operand addresses A, B, C.
// - Code 0 does nothing; code 1 adds A, B and C.
// - Code 2 subtracts B and C from A.
// - Code 3 gives A plus B minus C.
// - Code 4 gives the minimum, of A and B only when C is null.
// - Code 5 gives the maximum, of A and B only when C is null.
// - Code 6 gives the absolute value of A.
// - Code 7 gives minus A.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module usf_engine #(
  parameter int TICK_CYCLES = usf_pkg::TICK_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       parReq,
  output usf_pkg::usf_par_req_t      parInfo,
  input  wire logic                  parAck,
  input  wire logic [15:0]           parRdata
);
  logic [15:0] funcReg [usf_pkg::NBLK];
  logic [15:0] aReg    [usf_pkg::NBLK];
  logic [15:0] bReg    [usf_pkg::NBLK];
  logic [15:0] cReg    [usf_pkg::NBLK];
  logic [15:0] linkReg [usf_pkg::NBLK];
  logic [15:0] resReg  [usf_pkg::NBLK];
  logic [15:0] constReg[usf_pkg::NCONST];
  logic [15:0] opVal   [3];
  logic        runReg;
  logic [2:0]  periodReg;
  logic [31:0] tickCnt;
  logic [6:0]  unitCnt;
  logic        loopStart;
  usf_pkg::usf_state_t stReg, stNext;
  logic [4:0]  blkReg;
  logic [1:0]  opReg;

  // APB decode
  logic        setup, acc;
  logic [11:0] bOff, cOff;
  logic [4:0]  dBlk, dCon;
  logic [2:0]  dFld;
  logic        hitBlk, hitCon, mapped, cfgHit, cfgWe;
  logic [15:0] rdVal;

  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign bOff = paddr - usf_pkg::OFS_BLK_BASE;
  assign cOff = paddr - usf_pkg::OFS_CONST_BASE;
  assign dBlk = bOff[9:5];
  assign dFld = bOff[4:2];
  assign dCon = cOff[6:2];
  assign hitBlk = paddr >= usf_pkg::OFS_BLK_BASE && paddr < usf_pkg::OFS_BLK_END && dFld <= usf_pkg::FLD_LINK;
  assign hitCon = paddr >= usf_pkg::OFS_CONST_BASE && paddr < usf_pkg::OFS_CONST_END;
  assign cfgHit = paddr == usf_pkg::OFS_PERIOD || (hitBlk && dFld != usf_pkg::FLD_RES);
  assign cfgWe = acc && pwrite && cfgHit && !runReg;

  // Read mux and map check
  always_comb begin
    rdVal = 16'h0000;
    mapped = paddr[1:0] == 2'h0;
    if (paddr == usf_pkg::OFS_RUN) begin
      rdVal[usf_pkg::RUN_BIT] = runReg;
    end else if (paddr == usf_pkg::OFS_PERIOD) begin
      rdVal = {13'h0000, periodReg};
    end else if (paddr == usf_pkg::OFS_STATUS) begin
      rdVal[usf_pkg::STS_BUSY_BIT] = stReg != usf_pkg::ST_IDLE;
      rdVal[usf_pkg::STS_STEP_LSB +: 5] = blkReg;
    end else if (hitBlk) begin
      unique case (dFld)
        usf_pkg::FLD_FUNC: rdVal = funcReg[dBlk];
        usf_pkg::FLD_A:    rdVal = aReg[dBlk];
        usf_pkg::FLD_B:    rdVal = bReg[dBlk];
        usf_pkg::FLD_C:    rdVal = cReg[dBlk];
        usf_pkg::FLD_RES:  rdVal = resReg[dBlk];
        default:           rdVal = linkReg[dBlk];
      endcase
    end else if (hitCon) begin
      rdVal = constReg[dCon];
    end else begin
      mapped = 1'b0;
    end
  end

  // No wait state: answer is registered in the setup cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : {16'h0000, rdVal};
        pslverr <= !mapped || (pwrite && cfgHit && runReg);
      end
    end
  end

  // Run control and period select
  always_ff @(posedge core_clk) begin
    if (srst) begin
      runReg <= 1'b0;
      periodReg <= 3'h0;
    end else begin
      if (acc && pwrite && paddr == usf_pkg::OFS_RUN) begin
        runReg <= pwdata[usf_pkg::RUN_BIT];
      end
      if (cfgWe && paddr == usf_pkg::OFS_PERIOD && pwdata[15:0] <= 16'(usf_pkg::PERIOD_LAST)) begin
        periodReg <= pwdata[2:0];
      end
    end
  end

  // Per-block configuration storage
  for (genvar i = 0; i < usf_pkg::NBLK; i++) begin : g_blk
    always_ff @(posedge core_clk) begin
      if (srst) begin
        funcReg[i] <= usf_pkg::RESET_VAL;
        aReg[i] <= usf_pkg::RESET_VAL;
        bReg[i] <= usf_pkg::RESET_VAL;
        cReg[i] <= usf_pkg::RESET_VAL;
        linkReg[i] <= usf_pkg::RESET_VAL;
      end else if (cfgWe && hitBlk && dBlk == 5'(i)) begin
        if (dFld == usf_pkg::FLD_FUNC) funcReg[i] <= pwdata[15:0];
        if (dFld == usf_pkg::FLD_A) aReg[i] <= pwdata[15:0];
        if (dFld == usf_pkg::FLD_B) bReg[i] <= pwdata[15:0];
        if (dFld == usf_pkg::FLD_C) cReg[i] <= pwdata[15:0];
        if (dFld == usf_pkg::FLD_LINK) linkReg[i] <= pwdata[15:0];
      end
    end
  end

  // Loop period timer
  always_ff @(posedge core_clk) begin
    if (srst || !runReg) begin
      tickCnt <= 32'h00000000;
      unitCnt <= 7'h00;
      loopStart <= 1'b0;
    end else begin
      loopStart <= 1'b0;
      if (tickCnt == 32'(TICK_CYCLES - 1)) begin
        tickCnt <= 32'h00000000;
        if (unitCnt == usf_pkg::LOOP_MULT[periodReg] - 7'h01) begin
          unitCnt <= 7'h00;
          loopStart <= 1'b1;
        end else begin
          unitCnt <= unitCnt + 7'h01;
        end
      end else begin
        tickCnt <= tickCnt + 32'h00000001;
      end
    end
  end

  // Current block view
  logic [15:0] fn, opAddr, link;
  logic        badCfg, cNull, lastOp, opConst, opRes, lkConst, lkRes;
  logic [4:0]  opIdx, lkIdx;
  logic [15:0] opOff, lkOff;
  assign fn = funcReg[blkReg];
  assign link = linkReg[blkReg];
  assign cNull = cReg[blkReg] == usf_pkg::PAR_NULL;
  assign opAddr = opReg == 2'h0 ? aReg[blkReg] : (opReg == 2'h1 ? bReg[blkReg] : cReg[blkReg]);
  assign badCfg = fn > usf_pkg::FN_NEG || (fn != usf_pkg::FN_NOP && aReg[blkReg] == usf_pkg::PAR_NULL)
                  || (fn >= usf_pkg::FN_ADD && fn <= usf_pkg::FN_MAX && bReg[blkReg] == usf_pkg::PAR_NULL);
  assign lastOp = (fn >= usf_pkg::FN_ABS) ? opReg == 2'h0 : opReg == 2'h2;
  assign opOff = opAddr - usf_pkg::PAR_CONST_BASE;
  assign lkOff = link - usf_pkg::PAR_CONST_BASE;
  assign opIdx = opOff[4:0];
  assign lkIdx = lkOff[4:0];
  assign opConst = opAddr >= usf_pkg::PAR_CONST_BASE && opOff < 16'(usf_pkg::NCONST);
  assign lkConst = link >= usf_pkg::PAR_CONST_BASE && lkOff < 16'(usf_pkg::NCONST);
  assign opRes = opAddr >= usf_pkg::PAR_RES_BASE && opAddr < usf_pkg::PAR_RES_BASE + 16'(usf_pkg::NBLK);
  assign lkRes = link >= usf_pkg::PAR_RES_BASE && link < usf_pkg::PAR_RES_BASE + 16'(usf_pkg::NBLK);

  // Block arithmetic, widened then saturated
  logic signed [17:0] sa, sb, sc, wide, mn, mx;
  logic [15:0] calcVal;
  always_comb begin
    sa = 18'(signed'(opVal[0]));
    sb = 18'(signed'(opVal[1]));
    sc = 18'(signed'(opVal[2]));
    mn = (sa < sb) ? sa : sb;
    mx = (sa > sb) ? sa : sb;
    if (!cNull && sc < mn) mn = sc;
    if (!cNull && sc > mx) mx = sc;
    unique case (fn)
      usf_pkg::FN_ADD:               wide = sa + sb + sc;
      usf_pkg::FN_SUB:               wide = sa - sb - sc;
      usf_pkg::FN_ADD_THEN_SUBTRACT: wide = sa + sb - sc;
      usf_pkg::FN_MIN:               wide = mn;
      usf_pkg::FN_MAX:               wide = mx;
      usf_pkg::FN_ABS:               wide = (sa < 0) ? -sa : sa;
      usf_pkg::FN_NEG:               wide = -sa;
      default:                       wide = 18'sh00000;
    endcase
    if (wide > usf_pkg::SAT_MAX) wide = usf_pkg::SAT_MAX;
    if (wide < usf_pkg::SAT_MIN) wide = usf_pkg::SAT_MIN;
    calcVal = badCfg ? usf_pkg::RES_INVALID : wide[15:0];
  end

  // Sequencer next state
  always_comb begin
    stNext = stReg;
    unique case (stReg)
      usf_pkg::ST_IDLE:   if (loopStart && runReg) stNext = usf_pkg::ST_FETCH;
      usf_pkg::ST_FETCH:  begin
        if (badCfg || fn == usf_pkg::FN_NOP) stNext = usf_pkg::ST_CALC;
        else if (opAddr != usf_pkg::PAR_NULL && !opConst && !opRes) stNext = usf_pkg::ST_WAITRD;
        else if (lastOp) stNext = usf_pkg::ST_CALC;
      end
      usf_pkg::ST_WAITRD: if (parAck) stNext = lastOp ? usf_pkg::ST_CALC : usf_pkg::ST_FETCH;
      usf_pkg::ST_CALC:   stNext = usf_pkg::ST_LINK;
      usf_pkg::ST_LINK:   begin
        if (fn != usf_pkg::FN_NOP && link != usf_pkg::PAR_NULL && !lkConst && !lkRes) begin
          stNext = usf_pkg::ST_WAITWR;
        end else begin
          stNext = (blkReg == 5'(usf_pkg::NBLK - 1) || !runReg) ? usf_pkg::ST_IDLE : usf_pkg::ST_FETCH;
        end
      end
      usf_pkg::ST_WAITWR: begin
        if (parAck) begin
          stNext = (blkReg == 5'(usf_pkg::NBLK - 1) || !runReg) ? usf_pkg::ST_IDLE : usf_pkg::ST_FETCH;
        end
      end
    endcase
  end

  // Sequencer state, step order and operand fetch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stReg <= usf_pkg::ST_IDLE;
      blkReg <= 5'h00;
      opReg <= 2'h0;
      opVal <= '{16'h0000, 16'h0000, 16'h0000};
    end else begin
      stReg <= stNext;
      if (stReg == usf_pkg::ST_IDLE) begin
        blkReg <= 5'h00;
        opReg <= 2'h0;
        opVal <= '{16'h0000, 16'h0000, 16'h0000};
      end
      if (stReg == usf_pkg::ST_FETCH && stNext != usf_pkg::ST_WAITRD) begin
        if (opAddr == usf_pkg::PAR_NULL) opVal[opReg] <= 16'h0000;
        else if (opConst) opVal[opReg] <= constReg[opIdx];
        else opVal[opReg] <= resReg[opAddr[4:0]];
        opReg <= opReg + 2'h1;
      end
      if (stReg == usf_pkg::ST_WAITRD && parAck) begin
        opVal[opReg] <= parRdata;
        opReg <= opReg + 2'h1;
      end
      if ((stReg == usf_pkg::ST_LINK || stReg == usf_pkg::ST_WAITWR) && stNext == usf_pkg::ST_FETCH) begin
        blkReg <= blkReg + 5'h01;
        opReg <= 2'h0;
        opVal <= '{16'h0000, 16'h0000, 16'h0000};
      end
    end
  end

  // Parameter space requests, held until acknowledged
  always_ff @(posedge core_clk) begin
    if (srst) begin
      parReq <= 1'b0;
      parInfo <= '0;
    end else if (parReq) begin
      if (parAck) parReq <= 1'b0;
    end else if (stNext == usf_pkg::ST_WAITRD && stReg != usf_pkg::ST_WAITRD) begin
      parReq <= 1'b1;
      parInfo <= '{wr: 1'b0, addr: opAddr, wdata: 16'h0000};
    end else if (stReg == usf_pkg::ST_LINK && stNext == usf_pkg::ST_WAITWR) begin
      parReq <= 1'b1;
      parInfo <= '{wr: 1'b1, addr: link, wdata: resReg[blkReg]};
    end
  end

  // Results: engine only, bus writes never land here
  for (genvar i = 0; i < usf_pkg::NBLK; i++) begin : g_res
    always_ff @(posedge core_clk) begin
      if (srst) begin
        resReg[i] <= usf_pkg::RESET_VAL;
      end else if (stReg == usf_pkg::ST_CALC && blkReg == 5'(i) && fn != usf_pkg::FN_NOP) begin
        resReg[i] <= calcVal;
      end
    end
  end

  // Constants: a link into a slot wins over a bus write
  for (genvar i = 0; i < usf_pkg::NCONST; i++) begin : g_con
    always_ff @(posedge core_clk) begin
      if (srst) begin
        constReg[i] <= usf_pkg::RESET_VAL;
      end else if (stReg == usf_pkg::ST_LINK && fn != usf_pkg::FN_NOP && lkConst && lkIdx == 5'(i)) begin
        constReg[i] <= resReg[blkReg];
      end else if (acc && pwrite && hitCon && dCon == 5'(i)) begin
        constReg[i] <= pwdata[15:0];
      end
    end
  end

  // Checks
  logic [31:0] gapCnt, gapExp;
  logic        gapValid;
  assign gapExp = 32'(usf_pkg::LOOP_MULT[periodReg]) * 32'(TICK_CYCLES);
  always_ff @(posedge core_clk) begin
    if (srst || !runReg) begin
      gapCnt <= 32'h00000000;
      gapValid <= 1'b0;
    end else if (loopStart) begin
      gapCnt <= 32'h00000001;
      gapValid <= 1'b1;
    end else begin
      gapCnt <= gapCnt + 32'h00000001;
    end
  end

  property p_period;
    @(posedge core_clk) disable iff (srst) loopStart && gapValid |-> gapCnt == gapExp;
  endproperty
  a_period: assert property (p_period) else $error("Loop start spacing wrong");

  property p_refuse;
    @(posedge core_clk) disable iff (srst) acc && pwrite && runReg |-> !cfgWe && (!cfgHit || pslverr);
  endproperty
  a_refuse: assert property (p_refuse) else $error("Config write taken while running");

  property p_stopped;
    @(posedge core_clk) disable iff (srst) stReg == usf_pkg::ST_IDLE && !runReg |=> stReg == usf_pkg::ST_IDLE;
  endproperty
  a_stopped: assert property (p_stopped) else $error("Sequence started while stopped");

  property p_nulllink;
    @(posedge core_clk) disable iff (srst)
      stReg == usf_pkg::ST_LINK && link == usf_pkg::PAR_NULL |=> !parReq && stReg != usf_pkg::ST_WAITWR;
  endproperty
  a_nulllink: assert property (p_nulllink) else $error("Null link forwarded");

  property p_forward;
    @(posedge core_clk) disable iff (srst) stReg == usf_pkg::ST_LINK && stNext == usf_pkg::ST_WAITWR
      |=> parReq && parInfo.wr && parInfo.addr == $past(link) && parInfo.wdata == resReg[blkReg];
  endproperty
  a_forward: assert property (p_forward) else $error("Link write missing or wrong");

  property p_invalid;
    @(posedge core_clk) disable iff (srst)
      stReg == usf_pkg::ST_CALC && badCfg |=> resReg[blkReg] == usf_pkg::RES_INVALID;
  endproperty
  a_invalid: assert property (p_invalid) else $error("Invalid block not minus one");

  property p_order;
    @(posedge core_clk) disable iff (srst)
      stNext == usf_pkg::ST_FETCH && stReg != usf_pkg::ST_WAITRD && stReg != usf_pkg::ST_FETCH
      |=> blkReg == (($past(stReg) == usf_pkg::ST_IDLE) ? 5'h00 : $past(blkReg) + 5'h01);
  endproperty
  a_order: assert property (p_order) else $error("Block step order broken");

  property p_sat;
    @(posedge core_clk) disable iff (srst) stReg == usf_pkg::ST_CALC && !badCfg && fn != usf_pkg::FN_NOP
      |=> resReg[blkReg] != 16'h8000 && stReg == usf_pkg::ST_LINK;
  endproperty
  a_sat: assert property (p_sat) else $error("Result left saturation range");

  property p_abs;
    @(posedge core_clk) disable iff (srst) stReg == usf_pkg::ST_CALC && !badCfg && fn == usf_pkg::FN_ABS
      |=> !resReg[blkReg][15];
  endproperty
  a_abs: assert property (p_abs) else $error("Absolute value negative");
endmodule : usf_engine

/* pkg/usf_pkg.sv */
package usf_pkg;
  localparam int NBLK = 18;
  localparam int NCONST = 30;
  // APB register map, byte addresses
  localparam logic [11:0] OFS_RUN = 12'h000;
  localparam logic [11:0] OFS_PERIOD = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_BLK_BASE = 12'h100;
  localparam logic [11:0] OFS_BLK_END = 12'h340;
  localparam logic [11:0] OFS_CONST_BASE = 12'h400;
  localparam logic [11:0] OFS_CONST_END = 12'h478;
  // Word index of each field inside a 32-byte block window
  localparam logic [2:0] FLD_FUNC = 3'h0;
  localparam logic [2:0] FLD_A = 3'h1;
  localparam logic [2:0] FLD_B = 3'h2;
  localparam logic [2:0] FLD_C = 3'h3;
  localparam logic [2:0] FLD_RES = 3'h4;
  localparam logic [2:0] FLD_LINK = 3'h5;
  localparam int RUN_BIT = 0;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_STEP_LSB = 8;
  // Loop timing: base tick and period multipliers
  localparam int TICK_MS = 10;
  localparam int CLK_MHZ = 100;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] PERIOD_LAST = 3'h5;
  localparam logic [6:0] LOOP_MULT [6] = '{7'h01, 7'h02, 7'h05, 7'h0A, 7'h32, 7'h64};
  // Parameter space addresses
  localparam logic [15:0] PAR_NULL = 16'h0000;
  localparam logic [15:0] PAR_FREQ_REF = 16'h1101;
  localparam logic [15:0] PAR_CONST_BASE = 16'hE000;
  localparam logic [15:0] PAR_RES_BASE = 16'hE100;
  // Function codes
  localparam logic [15:0] FN_NOP = 16'h0000;
  localparam logic [15:0] FN_ADD = 16'h0001;
  localparam logic [15:0] FN_SUB = 16'h0002;
  localparam logic [15:0] FN_ADD_THEN_SUBTRACT = 16'h0003;
  localparam logic [15:0] FN_MIN = 16'h0004;
  localparam logic [15:0] FN_MAX = 16'h0005;
  localparam logic [15:0] FN_ABS = 16'h0006;
  localparam logic [15:0] FN_NEG = 16'h0007;
  localparam logic [15:0] RES_INVALID = 16'hFFFF;
  localparam logic signed [17:0] SAT_MAX = 18'sh07FFF;
  localparam logic signed [17:0] SAT_MIN = -18'sh07FFF;
  localparam logic [15:0] RESET_VAL = 16'h0000;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } usf_par_req_t;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAITRD, ST_CALC, ST_LINK, ST_WAITWR} usf_state_t;
endpackage : usf_pkg

/* sim/usf_par_model.sv */
`timescale 1ns/1ps
module usf_par_model (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  parReq,
  input  wire usf_pkg::usf_par_req_t parInfo,
  output logic                       parAck,
  output logic [15:0]                parRdata,
  output logic [15:0]                freqVal,
  output int                         freqWrites,
  output int                         otherWrites
);
  logic [1:0] waitCnt;
  logic       slow;

  // Answers each request after no wait or three wait cycles, alternating
  always_ff @(posedge core_clk) begin
    if (srst) begin
      parAck      <= 1'b0;
      parRdata    <= 16'h0000;
      waitCnt     <= 2'h0;
      slow        <= 1'b0;
      freqVal     <= 16'h0000;
      freqWrites  <= 0;
      otherWrites <= 0;
    end else if (parReq && !parAck && waitCnt == (slow ? 2'h3 : 2'h0)) begin
      parAck   <= 1'b1;
      waitCnt  <= 2'h0;
      slow     <= !slow;
      parRdata <= (parInfo.addr == 16'h2000) ? 16'h0064 : 16'h0000;
      if (parInfo.wr && parInfo.addr == usf_pkg::PAR_FREQ_REF) begin
        freqVal    <= parInfo.wdata;
        freqWrites <= freqWrites + 1;
      end else if (parInfo.wr) begin
        otherWrites <= otherWrites + 1;
      end
    end else begin
      parAck   <= 1'b0;
      parRdata <= ~parRdata; // Data is not held once the answer is gone
      if (parReq && !parAck) begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule : usf_par_model

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic                  core_clk = 1'b0;
  logic                  srst     = 1'b1;
  logic                  psel     = 1'b0;
  logic                  penable  = 1'b0;
  logic                  pwrite   = 1'b0;
  logic [11:0]           paddr    = 12'h000;
  logic [31:0]           pwdata   = 32'h00000000;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  parReq;
  usf_pkg::usf_par_req_t parInfo;
  logic                  parAck;
  logic [15:0]           parRdata;
  logic [15:0]           freqVal;
  int                    freqWrites;
  int                    otherWrites;
  int                    mismatches = 0;
  int                    n_compared = 0;
  int                    w;
  logic [31:0]           rdVal;
  logic                  rdErr;
  // Block setup table: function, operands A B C, link, expected result
  logic [15:0] fnT [11] = '{16'h1, 16'h2, 16'h4, 16'h7, 16'h6, 16'h9, 16'h1, 16'h4, 16'h3, 16'h0, 16'h5};
  logic [15:0] aT [11] = '{16'hE000, 16'hE100, 16'h2000, 16'hE001, 16'hE001, 16'hE000, 16'hE003, 16'hE000,
                           16'hE000, 16'h0000, 16'hE000};
  logic [15:0] bT [11] = '{16'hE001, 16'hE000, 16'hE002, 16'h0000, 16'h0000, 16'hE000, 16'hE003, 16'hE002,
                           16'hE001, 16'h0000, 16'hE001};
  logic [15:0] cT [11] = '{16'hE002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hE001,
                           16'hE002, 16'h0000, 16'hE002};
  logic [15:0] lnkT [11] = '{16'h1101, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  // Last entry: maximum over all three operands, C deciding the result
  logic [15:0] expT [11] = '{16'h0009, 16'h0004, 16'h0007, 16'h0003, 16'h0003, 16'hFFFF, 16'h7FFF, 16'hFFFD,
                             16'hFFFB, 16'h0000, 16'h0007};
  logic [15:0] cnsT [4] = '{16'h0005, 16'hFFFD, 16'h0007, 16'h7FFF};

  // Clock at 100 MHz
  always #5 core_clk = ~core_clk;

  usf_engine #(.TICK_CYCLES(10)) i_usf_engine (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .parReq(parReq), .parInfo(parInfo), .parAck(parAck), .parRdata(parRdata));

  usf_par_model i_usf_par_model (
    .core_clk(core_clk), .srst(srst), .parReq(parReq), .parInfo(parInfo), .parAck(parAck),
    .parRdata(parRdata), .freqVal(freqVal), .freqWrites(freqWrites), .otherWrites(otherWrites));

  // Byte address of one field of block n
  function automatic logic [11:0] blk(input int n, input logic [2:0] f);
    return usf_pkg::OFS_BLK_BASE + 12'(n * 32) + 12'(f) * 12'h004;
  endfunction : blk

  // One APB transfer; read data and error land in rdVal and rdErr
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 16) begin
      mismatches++;
      $display("unexpected pready timeout expected 1 seen %b", pready);
    end
    rdVal = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    apb(1'b0, usf_pkg::OFS_RUN, 32'h0);
    chk("run after reset", 32'h0, rdVal);
    apb(1'b0, usf_pkg::OFS_STATUS, 32'h0);
    chk("status after reset", 32'h0, rdVal);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rdErr});
    apb(1'b1, usf_pkg::OFS_PERIOD, 32'h5);
    apb(1'b1, usf_pkg::OFS_PERIOD, 32'h6);
    apb(1'b0, usf_pkg::OFS_PERIOD, 32'h0);
    chk("period select", 32'h5, rdVal);
    apb(1'b1, usf_pkg::OFS_PERIOD, 32'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, usf_pkg::OFS_CONST_BASE + 12'(k * 4), {16'h0, cnsT[k]});
    end
    for (int n = 0; n < 11; n++) begin
      apb(1'b1, blk(n, usf_pkg::FLD_FUNC), {16'h0, fnT[n]});
      apb(1'b1, blk(n, usf_pkg::FLD_A), {16'h0, aT[n]});
      apb(1'b1, blk(n, usf_pkg::FLD_B), {16'h0, bT[n]});
      apb(1'b1, blk(n, usf_pkg::FLD_C), {16'h0, cT[n]});
      apb(1'b1, blk(n, usf_pkg::FLD_LINK), {16'h0, lnkT[n]});
    end
    apb(1'b1, usf_pkg::OFS_RUN, 32'h1);
    apb(1'b1, blk(0, usf_pkg::FLD_FUNC), 32'h2);
    chk("refused write error", 32'h1, {31'h0, rdErr});
    apb(1'b0, blk(0, usf_pkg::FLD_FUNC), 32'h0);
    chk("function kept", 32'h1, rdVal);
    w = 0;
    while (freqWrites < 2 && w < 20000) begin
      @(posedge core_clk);
      w++;
    end
    chk("loops run", 32'h1, {31'h0, freqWrites >= 2});
    for (int n = 0; n < 11; n++) begin
      apb(1'b0, blk(n, usf_pkg::FLD_RES), 32'h0);
      chk("block result", {16'h0, expT[n]}, rdVal);
    end
    chk("frequency reference", 32'h9, {16'h0, freqVal});
    chk("unlinked writes", 32'h0, 32'(otherWrites));
    apb(1'b1, usf_pkg::OFS_RUN, 32'h0);
    apb(1'b1, blk(0, usf_pkg::FLD_RES), 32'h1234);
    chk("result write error", 32'h0, {31'h0, rdErr});
    apb(1'b0, blk(0, usf_pkg::FLD_RES), 32'h0);
    chk("result read only", 32'h9, rdVal);
    report_and_stop();
  end
endmodule : testbench
